// ### core/adcr_pkg.sv
// Operation
// - Index register bits 3:0 pick which data channels take local writes.
// - Second index register also picks the frame and data clock channels.
// - Global registers apply to all channels; local ones only to selected channels.
// - Clock channels take only a reduced subset of local channel settings.
// - First user pattern held globally: low byte then high byte, reset zero.
// - Second user pattern held globally as low and high byte, reset zero.
// - Stream control resets MSB first; bit 7 LSB first; bit 3 low encode rate.
// - Stream bits 1:0 set word length: 01 is 14 bits, 10 is 12 bits.
// - Stream bits 6:4 select lane and data rate arrangement.
// - Local status bit 0 powers down channel, bit 1 holds output reset.
// - Override: rate in bits 2:0, resolution bits 5:4, enable bit 6.
// - Reference bits 2:0 choose input span, default code 100 (2.0 V).
// - All writes immediate except override, which waits for transfer bit 0.
// - Override asking faster than default speed grade forces chip power-down.
package adcr_pkg;

  // Register addresses on the control port
  localparam logic [12:0] ADCR_ADDR_INDEX_LO   = 13'h0004;
  localparam logic [12:0] ADCR_ADDR_INDEX_HI   = 13'h0005;
  localparam logic [12:0] ADCR_ADDR_REF_SPAN   = 13'h0018;
  localparam logic [12:0] ADCR_ADDR_PAT1_LOW   = 13'h0019;
  localparam logic [12:0] ADCR_ADDR_PAT1_HIGH  = 13'h001a;
  localparam logic [12:0] ADCR_ADDR_PAT2_LOW   = 13'h001b;
  localparam logic [12:0] ADCR_ADDR_PAT2_HIGH  = 13'h001c;
  localparam logic [12:0] ADCR_ADDR_STREAM     = 13'h0021;
  localparam logic [12:0] ADCR_ADDR_CHAN_STAT  = 13'h0022;
  localparam logic [12:0] ADCR_ADDR_TRANSFER   = 13'h00ff;
  localparam logic [12:0] ADCR_ADDR_OVERRIDE   = 13'h0100;
  localparam logic [12:0] ADCR_ADDR_IO_PULL    = 13'h0101;
  localparam logic [12:0] ADCR_ADDR_CM_CTRL    = 13'h0102;
  localparam logic [12:0] ADCR_ADDR_SYNC       = 13'h0109;

  // Writable bit masks; open bits are zero here
  localparam logic [7:0] ADCR_MASK_INDEX_LO  = 8'h0f;
  localparam logic [7:0] ADCR_MASK_INDEX_HI  = 8'h3f;
  localparam logic [7:0] ADCR_MASK_REF_SPAN  = 8'h07;
  localparam logic [7:0] ADCR_MASK_STREAM    = 8'hfb;
  localparam logic [7:0] ADCR_MASK_CHAN_STAT = 8'h03;
  localparam logic [7:0] ADCR_MASK_OVERRIDE  = 8'h77;
  localparam logic [7:0] ADCR_MASK_IO_PULL   = 8'h01;
  localparam logic [7:0] ADCR_MASK_CM_CTRL   = 8'h08;
  localparam logic [7:0] ADCR_MASK_SYNC      = 8'h03;

  // Values after reset
  localparam logic [7:0] ADCR_RST_INDEX_LO  = 8'h0f;
  localparam logic [7:0] ADCR_RST_INDEX_HI  = 8'h3f;
  localparam logic [7:0] ADCR_RST_REF_SPAN  = 8'h04;
  localparam logic [7:0] ADCR_RST_PATTERN   = 8'h00;
  localparam logic [7:0] ADCR_RST_STREAM    = 8'h41;
  localparam logic [7:0] ADCR_RST_OVERRIDE  = 8'h00;
  localparam logic [7:0] ADCR_RST_IO        = 8'h00;

  // Field positions
  localparam int ADCR_BIT_LSB_FIRST   = 7;
  localparam int ADCR_BIT_LOW_RATE    = 3;
  localparam int ADCR_BIT_OVR_ENABLE  = 6;
  localparam int ADCR_BIT_TRANSFER    = 0;
  localparam int ADCR_BIT_CH_PDOWN    = 0;
  localparam int ADCR_BIT_CH_ORESET   = 1;
  localparam int ADCR_BIT_CM_PDOWN    = 3;

  // Sample rate codes of the override register
  localparam logic [2:0] ADCR_RATE_65 = 3'h3;

endpackage

// ### core/adcr_chan_slot.sv
`timescale 1ns/1ps
// Per-channel local state: power-down and output reset
module adcr_chan_slot
  import adcr_pkg::*;
#(
  parameter bit HAS_ORESET = 1'b1
)(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Local write
  input  wire logic       sel_i,
  input  wire logic       we_i,
  input  wire logic [1:0] wdata_i,
  // State
  output logic      [1:0] state_o
);

  logic [1:0] state_reg;
  logic [1:0] state_next;
  logic [1:0] keep_mask;

  // Clock channels drop the output reset bit
  assign keep_mask  = HAS_ORESET ? 2'h3 : 2'h1;
  assign state_next = (sel_i && we_i) ? (wdata_i & keep_mask) : state_reg;

  // Bits reset to zero
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_reg <= 2'h0;
    else
      state_reg <= state_next;
  end

  assign state_o = state_reg;

endmodule

// ### core/adcr_regs.sv
`timescale 1ns/1ps
// Converter configuration register bank behind the serial control port
module adcr_regs
  import adcr_pkg::*;
#(
  parameter int         NUM_DATA  = 8,
  parameter logic [2:0] RATE_GRADE = ADCR_RATE_65
)(
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Control port from the serial framer
  input  wire logic [12:0]         addr_i,
  input  wire logic                wr_en_i,
  input  wire logic [7:0]          wdata_i,
  input  wire logic                rd_en_i,
  output logic      [7:0]          rdata_o,
  // Global analog and pattern settings
  output logic      [2:0]          ref_span_o,
  output logic      [15:0]         pattern_one_o,
  output logic      [15:0]         pattern_two_o,
  // Serial stream settings
  output logic                     lsb_first_o,
  output logic      [2:0]          lane_mode_o,
  output logic                     low_encode_rate_o,
  output logic      [1:0]          word_bits_o,
  // Per-channel controls
  output logic      [NUM_DATA-1:0] ch_powerdown_o,
  output logic      [NUM_DATA-1:0] ch_output_reset_o,
  output logic      [1:0]          clk_ch_powerdown_o,
  // Applied override settings
  output logic                     override_en_o,
  output logic      [1:0]          resolution_o,
  output logic      [2:0]          sample_rate_o,
  output logic                     chip_powerdown_o,
  // I/O and sync controls
  output logic                     sdio_pulldown_off_o,
  output logic                     common_mode_generator_pd_o,
  output logic                     sync_enable_o,
  output logic                     sync_next_only_o
);

  localparam int NUM_SLOT = NUM_DATA + 2;

  // Stored registers
  logic [7:0] index_lo_reg;
  logic [7:0] index_hi_reg;
  logic [7:0] ref_span_reg;
  logic [7:0] pat1_low_reg;
  logic [7:0] pat1_high_reg;
  logic [7:0] pat2_low_reg;
  logic [7:0] pat2_high_reg;
  logic [7:0] stream_reg;
  logic [7:0] ovr_pending_reg;
  logic [7:0] ovr_active_reg;
  logic       chip_pd_reg;
  logic [7:0] io_pull_reg;
  logic [7:0] cm_ctrl_reg;
  logic [7:0] sync_reg;
  logic [7:0] rdata_reg;

  // Address decode
  wire        hit_index_lo = (addr_i == ADCR_ADDR_INDEX_LO);
  wire        hit_index_hi = (addr_i == ADCR_ADDR_INDEX_HI);
  wire        hit_ref      = (addr_i == ADCR_ADDR_REF_SPAN);
  wire        hit_p1l      = (addr_i == ADCR_ADDR_PAT1_LOW);
  wire        hit_p1h      = (addr_i == ADCR_ADDR_PAT1_HIGH);
  wire        hit_p2l      = (addr_i == ADCR_ADDR_PAT2_LOW);
  wire        hit_p2h      = (addr_i == ADCR_ADDR_PAT2_HIGH);
  wire        hit_stream   = (addr_i == ADCR_ADDR_STREAM);
  wire        hit_chan     = (addr_i == ADCR_ADDR_CHAN_STAT);
  wire        hit_xfer     = (addr_i == ADCR_ADDR_TRANSFER);
  wire        hit_ovr      = (addr_i == ADCR_ADDR_OVERRIDE);
  wire        hit_io       = (addr_i == ADCR_ADDR_IO_PULL);
  wire        hit_cm       = (addr_i == ADCR_ADDR_CM_CTRL);
  wire        hit_sync     = (addr_i == ADCR_ADDR_SYNC);

  // Write strobes; one address per cycle, so at most one fires
  wire        wr_index_lo  = wr_en_i && hit_index_lo;
  wire        wr_index_hi  = wr_en_i && hit_index_hi;
  wire        wr_ref       = wr_en_i && hit_ref;
  wire        wr_p1l       = wr_en_i && hit_p1l;
  wire        wr_p1h       = wr_en_i && hit_p1h;
  wire        wr_p2l       = wr_en_i && hit_p2l;
  wire        wr_p2h       = wr_en_i && hit_p2h;
  wire        wr_stream    = wr_en_i && hit_stream;
  wire        wr_ovr       = wr_en_i && hit_ovr;
  wire        wr_io        = wr_en_i && hit_io;
  wire        wr_cm        = wr_en_i && hit_cm;
  wire        wr_sync      = wr_en_i && hit_sync;

  // Channel selection: data channels split over both index registers, clock pair in the upper one
  wire [NUM_SLOT-1:0] chan_sel;
  assign chan_sel[3:0]          = index_lo_reg[3:0];
  assign chan_sel[NUM_DATA-1:4] = index_hi_reg[NUM_DATA-5:0];
  assign chan_sel[NUM_SLOT-1:NUM_DATA] = index_hi_reg[5:4];

  // Transfer strobe applies the pending override; the bit itself is not stored
  wire        xfer_go     = wr_en_i && hit_xfer && wdata_i[ADCR_BIT_TRANSFER];
  // An enabled override that asks for a faster grade than the part has is refused
  wire        ovr_upgrade = ovr_pending_reg[ADCR_BIT_OVR_ENABLE]
                            && (ovr_pending_reg[2:0] > RATE_GRADE);

  // Index registers, plain write
  // Reset selects every slot, so a local write made before any index write reaches all of them
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      index_lo_reg <= ADCR_RST_INDEX_LO;
      index_hi_reg <= ADCR_RST_INDEX_HI;
    end
    else
    begin
      if (wr_index_lo)
        index_lo_reg <= wdata_i & ADCR_MASK_INDEX_LO;
      if (wr_index_hi)
        index_hi_reg <= wdata_i & ADCR_MASK_INDEX_HI;
    end
  end

  // Reference span; takes effect on the write itself
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ref_span_reg <= ADCR_RST_REF_SPAN;
    else if (wr_ref)
      ref_span_reg <= wdata_i & ADCR_MASK_REF_SPAN;
  end

  // User patterns, global so channel selection is ignored
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pat1_low_reg  <= ADCR_RST_PATTERN;
      pat1_high_reg <= ADCR_RST_PATTERN;
      pat2_low_reg  <= ADCR_RST_PATTERN;
      pat2_high_reg <= ADCR_RST_PATTERN;
    end
    else
    begin
      if (wr_p1l)
        pat1_low_reg <= wdata_i;
      if (wr_p1h)
        pat1_high_reg <= wdata_i;
      if (wr_p2l)
        pat2_low_reg <= wdata_i;
      if (wr_p2h)
        pat2_high_reg <= wdata_i;
    end
  end

  // Stream control; bit 2 is open and stays zero
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      stream_reg <= ADCR_RST_STREAM;
    else if (wr_stream)
      stream_reg <= wdata_i & ADCR_MASK_STREAM;
  end

  // Override: pending copy written directly, active copy only on transfer
  wire        xfer_apply  = xfer_go && !ovr_upgrade;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ovr_pending_reg <= ADCR_RST_OVERRIDE;
    else if (wr_ovr)
      ovr_pending_reg <= wdata_i & ADCR_MASK_OVERRIDE;
  end

  // A refused transfer leaves the last applied setting running
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ovr_active_reg <= ADCR_RST_OVERRIDE;
    else if (xfer_apply)
      ovr_active_reg <= ovr_pending_reg;
  end

  // Chip power-down follows the verdict of the latest transfer; a legal one releases it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      chip_pd_reg <= 1'b0;
    else if (xfer_go)
      chip_pd_reg <= ovr_upgrade;
  end

  // I/O control and sync registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      io_pull_reg <= ADCR_RST_IO;
      cm_ctrl_reg <= ADCR_RST_IO;
      sync_reg    <= ADCR_RST_IO;
    end
    else
    begin
      if (wr_io)
        io_pull_reg <= wdata_i & ADCR_MASK_IO_PULL;
      if (wr_cm)
        cm_ctrl_reg <= wdata_i & ADCR_MASK_CM_CTRL;
      if (wr_sync)
        sync_reg <= wdata_i & ADCR_MASK_SYNC;
    end
  end

  // Per-channel slots; the last two are the data and frame clock drivers
  wire [1:0] slot_state [NUM_SLOT];
  wire       chan_we = wr_en_i && hit_chan;

  // Clock slots are built without the output reset bit
  genvar g;
  generate
    for (g = 0; g < NUM_SLOT; g++)
    begin : g_slot
      adcr_chan_slot #(
        .HAS_ORESET (g < NUM_DATA)
      ) u_slot (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .sel_i   (chan_sel[g]),
        .we_i    (chan_we),
        .wdata_i (wdata_i[1:0]),
        .state_o (slot_state[g])
      );
      if (g < NUM_DATA)
      begin : g_data
        assign ch_powerdown_o[g]    = slot_state[g][ADCR_BIT_CH_PDOWN];
        assign ch_output_reset_o[g] = slot_state[g][ADCR_BIT_CH_ORESET];
      end
      else
      begin : g_clk
        assign clk_ch_powerdown_o[g-NUM_DATA] = slot_state[g][ADCR_BIT_CH_PDOWN];
      end
    end
  endgenerate

  // Local readback shows the lowest selected channel; none selected reads zero
  logic [1:0] chan_rd;
  always_comb
  begin
    chan_rd = 2'h0;
    for (int i = NUM_SLOT - 1; i >= 0; i--)
    begin
      if (chan_sel[i])
        chan_rd = slot_state[i];
    end
  end

  // Read multiplexer; unmapped addresses and the transfer register read zero
  wire [7:0] rd_mux =
      hit_index_lo ? index_lo_reg :
      hit_index_hi ? index_hi_reg :
      hit_ref      ? ref_span_reg :
      hit_p1l      ? pat1_low_reg :
      hit_p1h      ? pat1_high_reg :
      hit_p2l      ? pat2_low_reg :
      hit_p2h      ? pat2_high_reg :
      hit_stream   ? stream_reg :
      hit_chan     ? {6'h00, chan_rd} :
      hit_ovr      ? ovr_pending_reg :
      hit_io       ? io_pull_reg :
      hit_cm       ? cm_ctrl_reg :
      hit_sync     ? sync_reg : 8'h00;

  // Read data registered, valid the cycle after rd_en_i
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_reg <= 8'h00;
    else if (rd_en_i)
      rdata_reg <= rd_mux;
  end

  // Outputs straight from the stored registers
  assign rdata_o                    = rdata_reg;
  assign ref_span_o                 = ref_span_reg[2:0];
  assign pattern_one_o              = {pat1_high_reg, pat1_low_reg};
  assign pattern_two_o              = {pat2_high_reg, pat2_low_reg};

  // Stream control fields
  assign lsb_first_o                = stream_reg[ADCR_BIT_LSB_FIRST];
  assign lane_mode_o                = stream_reg[6:4];
  assign low_encode_rate_o          = stream_reg[ADCR_BIT_LOW_RATE];
  assign word_bits_o                = stream_reg[1:0];

  // Applied override and its power-down verdict
  assign override_en_o              = ovr_active_reg[ADCR_BIT_OVR_ENABLE];
  assign resolution_o               = ovr_active_reg[5:4];
  assign sample_rate_o              = ovr_active_reg[2:0];
  assign chip_powerdown_o           = chip_pd_reg;

  // I/O and sync controls; open bits never reach a pin
  assign sdio_pulldown_off_o        = io_pull_reg[0];
  assign common_mode_generator_pd_o = cm_ctrl_reg[ADCR_BIT_CM_PDOWN];
  assign sync_enable_o              = sync_reg[0];
  assign sync_next_only_o           = sync_reg[1];

endmodule

// ### bench/adcr_regs_properties.sv
`timescale 1ns/1ps
// Concurrent checks on the register bank ports
module adcr_regs_properties
  import adcr_pkg::*;
#(
  parameter int         NUM_DATA   = 8,
  parameter logic [2:0] RATE_GRADE = ADCR_RATE_65
)(
  // Clock, reset and control port
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [12:0] addr_i,
  input wire logic        wr_en_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        rd_en_i,
  input wire logic [7:0]  rdata_o,
  // Settings
  input wire logic [2:0]  ref_span_o,
  input wire logic [15:0] pattern_one_o,
  input wire logic [15:0] pattern_two_o,
  input wire logic        lsb_first_o,
  input wire logic [2:0]  lane_mode_o,
  input wire logic        low_encode_rate_o,
  input wire logic [1:0]  word_bits_o,
  input wire logic        override_en_o,
  input wire logic [1:0]  resolution_o,
  input wire logic [2:0]  sample_rate_o,
  input wire logic        chip_powerdown_o
);
  // Shadow of the pending override, so a transfer is judged without the body
  logic [7:0] pend_reg;
  wire        ovr_wr  = wr_en_i && addr_i == ADCR_ADDR_OVERRIDE;
  wire        upgrade = pend_reg[ADCR_BIT_OVR_ENABLE] && pend_reg[2:0] > RATE_GRADE;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pend_reg <= ADCR_RST_OVERRIDE;
    else if (ovr_wr)
      pend_reg <= wdata_i & ADCR_MASK_OVERRIDE;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Steps of a write and of a transfer
  sequence s_wr(logic [12:0] a);
    wr_en_i && addr_i == a;
  endsequence
  sequence s_xfer;
    wr_en_i && addr_i == ADCR_ADDR_TRANSFER && wdata_i[0];
  endsequence

  chk_pat_one_low: assert property (
    s_wr(ADCR_ADDR_PAT1_LOW) |=> pattern_one_o[7:0] == $past(wdata_i)) else $error("pattern one low not stored");
  chk_pat_two_high: assert property (
    s_wr(ADCR_ADDR_PAT2_HIGH) |=> pattern_two_o[15:8] == $past(wdata_i)) else $error("pattern two high not stored");
  chk_stream_fields: assert property (
    s_wr(ADCR_ADDR_STREAM) |=> lsb_first_o == $past(wdata_i[7]) && lane_mode_o == $past(wdata_i[6:4])
      && low_encode_rate_o == $past(wdata_i[3])) else $error("stream control fields wrong");
  chk_word_length: assert property (
    s_wr(ADCR_ADDR_STREAM) |=> word_bits_o == $past(wdata_i[1:0])) else $error("word length wrong");
  chk_ref_span: assert property (
    s_wr(ADCR_ADDR_REF_SPAN) |=> ref_span_o == $past(wdata_i[2:0])) else $error("span code wrong");
  chk_ovr_pending: assert property (
    s_wr(ADCR_ADDR_OVERRIDE) |=> $stable(sample_rate_o) && $stable(override_en_o)) else $error("override applied early");
  chk_xfer_apply: assert property (
    s_xfer ##0 !upgrade |=> sample_rate_o == $past(pend_reg[2:0]) && resolution_o == $past(pend_reg[5:4])
      && override_en_o == $past(pend_reg[6]) && !chip_powerdown_o) else $error("transfer not applied");
  chk_xfer_refuse: assert property (
    s_xfer ##0 upgrade |=> chip_powerdown_o && $stable(sample_rate_o)) else $error("upgrade not refused");
  chk_open_read: assert property (
    rd_en_i && addr_i == ADCR_ADDR_REF_SPAN |=> rdata_o[7:3] == 5'h00) else $error("open bits read nonzero");
  chk_xfer_read: assert property (
    rd_en_i && addr_i == ADCR_ADDR_TRANSFER |=> rdata_o == 8'h00) else $error("transfer reads nonzero");
endmodule

// ### bench/adcr_host_model.sv
`timescale 1ns/1ps
// Host side of the control port: one write or read per call
module adcr_host_model
  import adcr_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Control port toward the bank
  output logic      [12:0] addr_o,
  output logic             wr_en_o,
  output logic      [7:0]  wdata_o,
  output logic             rd_en_o,
  input  wire logic [7:0]  rdata_i
);
  // Idle bus shows inverted last values, so stale data never passes for a request
  initial
  begin
    addr_o  = 13'h0000;
    wdata_o = 8'h00;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
  end

  // Write held for one rising edge
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_en_o = 1'b1;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask

  // Read data is registered, so it is settled by the next falling edge
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o  = a;
    rd_en_o = 1'b1;
    @(negedge clk_i);
    rd_en_o = 1'b0;
    addr_o  = ~a;
    d       = rdata_i;
  endtask
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top
  import adcr_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [12:0] addr;
  logic wr_en, rd_en, lsb, low_rate, ovr_en, chip_pd, pull_off, cm_pd, sync_en, sync_next;
  logic [7:0] wdata, rdata, ch_pd, ch_rst;
  logic [2:0] span, lane, rate;
  logic [15:0] pat1, pat2;
  logic [1:0] wbits, clk_pd, res;
  int error_cnt = 0;
  int checked = 0;
  // Address table with reset values and read-back after writing all ones
  logic [12:0] ra [13] = '{13'h004, 13'h005, 13'h018, 13'h019, 13'h01a, 13'h01b, 13'h01c, 13'h021, 13'h022,
                           13'h100, 13'h101, 13'h102, 13'h109};
  logic [7:0] rv [13] = '{8'h0f, 8'h3f, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h41, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] mv [13] = '{8'h0f, 8'h3f, 8'h07, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfb, 8'h03, 8'h77, 8'h01, 8'h08, 8'h03};

  always #2 clk_i = ~clk_i;

  adcr_regs #(.NUM_DATA(8), .RATE_GRADE(ADCR_RATE_65)) i_adcr_regs (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wr_en_i(wr_en), .wdata_i(wdata), .rd_en_i(rd_en),
    .rdata_o(rdata), .ref_span_o(span), .pattern_one_o(pat1), .pattern_two_o(pat2), .lsb_first_o(lsb),
    .lane_mode_o(lane), .low_encode_rate_o(low_rate), .word_bits_o(wbits), .ch_powerdown_o(ch_pd),
    .ch_output_reset_o(ch_rst), .clk_ch_powerdown_o(clk_pd), .override_en_o(ovr_en), .resolution_o(res),
    .sample_rate_o(rate), .chip_powerdown_o(chip_pd), .sdio_pulldown_off_o(pull_off),
    .common_mode_generator_pd_o(cm_pd), .sync_enable_o(sync_en), .sync_next_only_o(sync_next));
  adcr_host_model i_adcr_host_model (
    .clk_i(clk_i), .addr_o(addr), .wr_en_o(wr_en), .wdata_o(wdata), .rd_en_o(rd_en), .rdata_i(rdata));

  task automatic final_report;
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Reset values of every register and of the stream and span outputs
  task automatic t_reset;
    logic [7:0] d;
    for (int i = 0; i < 13; i++)
    begin
      i_adcr_host_model.rd(ra[i], d);
      `CHK(d, rv[i])
    end
    `CHK({lsb, lane, low_rate, wbits, span}, 10'h10c)
  endtask

  // All ones everywhere: open bits drop, stream, pattern, channel and I/O fields decode, override stays pending
  task automatic t_open_bits;
    logic [7:0] d;
    for (int i = 0; i < 13; i++)
    begin
      i_adcr_host_model.wr(ra[i], 8'hff);
      i_adcr_host_model.rd(ra[i], d);
      `CHK(d, mv[i])
    end
    `CHK({lsb, lane, low_rate, wbits}, 7'h7f)
    `CHK({pat2, pat1}, 32'hffffffff)
    `CHK({ch_pd, ch_rst, clk_pd}, 18'h3ffff)
    `CHK({pull_off, cm_pd, sync_en, sync_next, ovr_en, rate}, 8'hf0)
    i_adcr_host_model.rd(ADCR_ADDR_TRANSFER, d);
    `CHK(d, 8'h00)
  endtask

  // Upgrade refused, then every legal rate code applied by transfer only
  task automatic t_override;
    i_adcr_host_model.wr(ADCR_ADDR_TRANSFER, 8'h01);
    `CHK({chip_pd, ovr_en, rate}, 5'h10)
    for (int r = 0; r < 4; r++)
    begin
      i_adcr_host_model.wr(ADCR_ADDR_OVERRIDE, 8'h50 | 8'(r));
      `CHK(rate, (r == 0) ? 3'h0 : 3'(r - 1))
      i_adcr_host_model.wr(ADCR_ADDR_TRANSFER, 8'h01);
      `CHK({chip_pd, ovr_en, res, rate}, {4'h5, 3'(r)})
    end
    for (int s = 0; s < 5; s++)
    begin
      i_adcr_host_model.wr(ADCR_ADDR_REF_SPAN, 8'(s));
      `CHK(span, 3'(s))
    end
  endtask

  // Narrow selections steer local writes; global writes ignore them
  task automatic t_local;
    logic [7:0] d;
    i_adcr_host_model.wr(ADCR_ADDR_CHAN_STAT, 8'h00);
    i_adcr_host_model.wr(ADCR_ADDR_INDEX_LO, 8'h04);
    i_adcr_host_model.wr(ADCR_ADDR_INDEX_HI, 8'h00);
    i_adcr_host_model.wr(ADCR_ADDR_CHAN_STAT, 8'h03);
    `CHK({ch_pd, ch_rst, clk_pd}, 18'h01010)
    i_adcr_host_model.wr(ADCR_ADDR_INDEX_LO, 8'h00);
    i_adcr_host_model.wr(ADCR_ADDR_INDEX_HI, 8'h21);
    i_adcr_host_model.wr(ADCR_ADDR_CHAN_STAT, 8'h03);
    `CHK({ch_pd, ch_rst, clk_pd}, 18'h05052)
    i_adcr_host_model.rd(ADCR_ADDR_CHAN_STAT, d);
    `CHK(d, 8'h03)
    i_adcr_host_model.wr(ADCR_ADDR_INDEX_HI, 8'h20);
    i_adcr_host_model.rd(ADCR_ADDR_CHAN_STAT, d);
    `CHK(d, 8'h01)
    i_adcr_host_model.wr(ADCR_ADDR_CHAN_STAT, 8'h02);
    `CHK({ch_pd, ch_rst, clk_pd}, 18'h05050)
    i_adcr_host_model.wr(ADCR_ADDR_PAT1_LOW, 8'h5a);
    i_adcr_host_model.wr(ADCR_ADDR_STREAM, 8'h12);
    `CHK({pat1, lsb, lane, low_rate, wbits}, 23'h7fad0a)
  endtask

  // Reset in mid-run must bring every register back, and the power-down, override enable, stream and span outputs
  task automatic t_mid_reset;
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    `CHK({chip_pd, ovr_en, ch_pd, clk_pd}, 12'h000)
    t_reset();
  endtask

  // Run cut short if a sequence hangs
  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_open_bits();
    t_override();
    t_local();
    t_mid_reset();
    final_report();
  end
endmodule

bind adcr_regs adcr_regs_properties #(.NUM_DATA(NUM_DATA), .RATE_GRADE(RATE_GRADE)) i_adcr_regs_properties (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_en_i(wr_en_i), .wdata_i(wdata_i), .rd_en_i(rd_en_i),
  .rdata_o(rdata_o), .ref_span_o(ref_span_o), .pattern_one_o(pattern_one_o), .pattern_two_o(pattern_two_o),
  .lsb_first_o(lsb_first_o), .lane_mode_o(lane_mode_o), .low_encode_rate_o(low_encode_rate_o),
  .word_bits_o(word_bits_o), .override_en_o(override_en_o), .resolution_o(resolution_o),
  .sample_rate_o(sample_rate_o), .chip_powerdown_o(chip_powerdown_o));
